// ### verilog/ccpt_timer.sv
/*
  Capture/compare/PWM timer: one counter, four channels, overflow and match
  triggers for the event routing network, optional dead-time on PWM channels of instance 0.
  Assumes all inputs synchronous to sys_clk_i; control bits are plain ports.
*/
module ccpt_timer #(
  parameter bit WIDE     = 1'b0,
  parameter int INST_IDX = 0
) (
  input  wire logic                                         sys_clk_i,
  input  wire logic                                         reset_n_i,
  input  wire logic                                         run_i,
  input  wire logic                                         evt_count_i,
  input  wire logic                                         count_evt_i,
  input  wire logic                                         ovf_clr_i,
  input  wire logic [ccpt_pkg::CH_N-1:0][1:0]               chan_mode_i,
  input  wire logic [ccpt_pkg::CH_N-1:0]                    chan_cap_evt_i,
  input  wire logic [ccpt_pkg::CH_N-1:0][(WIDE ? ccpt_pkg::WIDE_W : ccpt_pkg::STD_W)-1:0]
                                                            chan_thr_i,
  input  wire logic                                         dt_enable_i,
  input  wire logic [ccpt_pkg::DT_W-1:0]                    dt_cycles_i,
  output logic      [(WIDE ? ccpt_pkg::WIDE_W : ccpt_pkg::STD_W)-1:0]
                                                            count_o,
  output logic                                              ovf_flag_o,
  output logic                                              ovf_trig_o,
  output logic      [ccpt_pkg::CH_N-1:0]                    match_trig_o,
  output logic      [ccpt_pkg::CH_N-1:0][(WIDE ? ccpt_pkg::WIDE_W : ccpt_pkg::STD_W)-1:0]
                                                            cap_val_o,
  output logic      [ccpt_pkg::CH_N-1:0]                    chan_out_o,
  output logic      [ccpt_pkg::CH_N-1:0]                    chan_out_n_o
);

  localparam int W = WIDE ? ccpt_pkg::WIDE_W : ccpt_pkg::STD_W;
  localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

  typedef struct packed {
    logic [W-1:0]                       cnt;
    logic                               ovf;
    logic                               trig;
    logic                               evt_q;
    logic [ccpt_pkg::CH_N-1:0]          cap_q;
    logic [ccpt_pkg::CH_N-1:0]          lvl;
    logic [ccpt_pkg::CH_N-1:0]          match;
    logic [ccpt_pkg::CH_N-1:0][W-1:0]   cap;
    logic [ccpt_pkg::CH_N-1:0][W-1:0]   act;
  } ccpt_state_t;

  ccpt_state_t               r;
  ccpt_state_t               next_r;
  logic                      tick;
  logic                      wrap;
  logic [ccpt_pkg::CH_N-1:0] pwm_sel;

  // time base while run_i is high: every clock, or each rising edge of the event input
  assign tick = run_i && (evt_count_i ? (count_evt_i && !r.evt_q) : 1'b1);
  assign wrap = tick && (r.cnt == CNT_MAX);

  always_comb
  begin
    next_r       = r;
    next_r.evt_q = count_evt_i;
    next_r.cap_q = chan_cap_evt_i;
    next_r.trig  = 1'b0;
    next_r.match = '0;
    pwm_sel      = '0;

    if (tick)
      next_r.cnt = r.cnt + 1'b1;

    // overflow set wins over a clear in the same cycle
    if (wrap)
    begin
      next_r.ovf  = 1'b1;
      next_r.trig = 1'b1;
    end
    else if (ovf_clr_i)
      next_r.ovf = ccpt_pkg::OVF_RST;

    for (int c = 0; c < ccpt_pkg::CH_N; c++)
    begin
      // PWM value reloads only at wrap; other modes track the threshold
      next_r.act[c] = chan_thr_i[c];
      unique case (ccpt_pkg::ccpt_mode_t'(chan_mode_i[c]))
        ccpt_pkg::MODE_CAPTURE:
        begin
          next_r.lvl[c] = 1'b0;
          if (chan_cap_evt_i[c] && !r.cap_q[c])
            next_r.cap[c] = r.cnt;
        end
        ccpt_pkg::MODE_COMPARE:
        begin
          next_r.lvl[c]   = (r.cnt >= chan_thr_i[c]);
          next_r.match[c] = tick && (r.cnt == chan_thr_i[c]);
        end
        ccpt_pkg::MODE_PWM:
        begin
          pwm_sel[c]    = 1'b1;
          next_r.lvl[c] = (r.cnt < r.act[c]);
          if (!wrap)
            next_r.act[c] = r.act[c];
          next_r.match[c] = wrap;
        end
        default:
        begin
          next_r.lvl[c] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign count_o      = r.cnt;
  assign ovf_flag_o   = r.ovf;
  assign ovf_trig_o   = r.trig;
  assign match_trig_o = r.match;
  assign cap_val_o    = r.cap;

  for (genvar g = 0; g < ccpt_pkg::CH_N; g++)
  begin : g_chan
    // only instance 0 of either width carries the inserter
    ccpt_deadtime #(
      .PRESENT (INST_IDX == 0)
    ) u_dt (
      .sys_clk_i   (sys_clk_i),
      .reset_n_i   (reset_n_i),
      .lvl_i       (r.lvl[g]),
      .enable_i    (dt_enable_i && pwm_sel[g]),
      .dt_cycles_i (dt_cycles_i),
      .hi_o        (chan_out_o[g]),
      .lo_o        (chan_out_n_o[g])
    );

    property p_cap;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (chan_mode_i[g] == ccpt_pkg::MODE_CAPTURE) && chan_cap_evt_i[g] && !r.cap_q[g]
        |=> cap_val_o[g] == $past(r.cnt);
    endproperty
    a_cap: assert property (p_cap) else $error("capture value wrong");

    property p_cmp;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (chan_mode_i[g] == ccpt_pkg::MODE_COMPARE)
        |=> r.lvl[g] == ($past(r.cnt) >= $past(chan_thr_i[g]));
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare level wrong");

    property p_pwm;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (chan_mode_i[g] == ccpt_pkg::MODE_PWM)
        |=> r.lvl[g] == ($past(r.cnt) < $past(r.act[g]));
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm level wrong");

    property p_pwm_load;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (chan_mode_i[g] == ccpt_pkg::MODE_PWM) && wrap
        |=> r.act[g] == $past(chan_thr_i[g]) ##1 1'b1;
    endproperty
    a_pwm_load: assert property (p_pwm_load) else $error("pwm reload wrong");

    property p_idle;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (chan_mode_i[g] == ccpt_pkg::MODE_CAPTURE) ##1
        (chan_mode_i[g] == ccpt_pkg::MODE_CAPTURE) |-> !r.lvl[g];
    endproperty
    a_idle: assert property (p_idle) else $error("capture channel drives level");
  end

  property p_inc;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    tick && (r.cnt != CNT_MAX) |=> count_o == W'($past(r.cnt) + 1'b1);
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    wrap |=> (count_o == '0) && ovf_flag_o && ovf_trig_o ##1 !ovf_trig_o;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap misbehaved");

  property p_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !tick |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");

  property p_evt_count;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    run_i && evt_count_i && !count_evt_i |=> $stable(count_o);
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("event mode counted");

  property p_ovf_sticky;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ovf_flag_o && (!ovf_clr_i || wrap) |=> ovf_flag_o;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_trig_cause;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ovf_trig_o |-> $past(wrap);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("spurious trigger");

  property p_width;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ovf_trig_o |-> $past(count_o) == CNT_MAX;
  endproperty
  a_width: assert property (p_width) else $error("wrap below maximum");

  property p_cov_wrap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    wrap;
  endproperty
  c_wrap: cover property (p_cov_wrap);

  property p_cov_cap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    chan_mode_i[0] == ccpt_pkg::MODE_CAPTURE && chan_cap_evt_i[0] && !r.cap_q[0];
  endproperty
  c_cap: cover property (p_cov_cap);

  property p_cov_pwm;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    chan_mode_i[1] == ccpt_pkg::MODE_PWM && r.lvl[1] ##1 !r.lvl[1];
  endproperty
  c_pwm: cover property (p_cov_pwm);

  property p_cov_match;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    match_trig_o[2];
  endproperty
  c_match: cover property (p_cov_match);

endmodule : ccpt_timer

// ### shared/ccpt_pkg.sv
/*
  Shared constants for the capture/compare/PWM timer: widths, channel count,
  channel mode codes and reset values.
  Assumes nothing of its surroundings; included by every timer design file.
*/
package ccpt_pkg;

  localparam int CH_N  = 4;
  localparam int STD_W = 16;
  localparam int WIDE_W = 32;
  localparam int DT_W  = 8;

  localparam logic       OVF_RST  = 1'b0;
  localparam logic [7:0] DT_CLEAR = 8'h00;

  // code 2'b00 is not a mode: channel idles with output low
  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_PWM     = 2'b11
  } ccpt_mode_t;

endpackage : ccpt_pkg

// ### verilog/ccpt_deadtime.sv
/*
  Dead-time inserter for one channel: turns a level into a true and a
  complement output with a gap of both low after every change.
  Assumes a single clock domain and level inputs synchronous to sys_clk_i.
*/
module ccpt_deadtime #(
  parameter bit PRESENT = 1'b0
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    lvl_i,
  input  wire logic                    enable_i,
  input  wire logic [ccpt_pkg::DT_W-1:0] dt_cycles_i,
  output logic                         hi_o,
  output logic                         lo_o
);

  typedef struct packed {
    logic                      prev;
    logic [ccpt_pkg::DT_W-1:0] gap;
    logic                      hi;
    logic                      lo;
  } ccpt_dt_state_t;

  ccpt_dt_state_t r;
  ccpt_dt_state_t next_r;
  logic           active;

  // hardware without the inserter ignores the enable
  assign active = PRESENT && enable_i;

  always_comb
  begin
    next_r      = r;
    next_r.prev = lvl_i;
    if (!active)
    begin
      next_r.gap = ccpt_pkg::DT_CLEAR;
      next_r.hi  = lvl_i;
      next_r.lo  = ~lvl_i;
    end
    else if (lvl_i != r.prev)
    begin
      next_r.gap = dt_cycles_i;
      next_r.hi  = 1'b0;
      next_r.lo  = 1'b0;
    end
    else if (r.gap != ccpt_pkg::DT_CLEAR)
    begin
      next_r.gap = r.gap - 1'b1;
      next_r.hi  = 1'b0;
      next_r.lo  = 1'b0;
    end
    else
    begin
      next_r.hi = lvl_i;
      next_r.lo = ~lvl_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign hi_o = r.hi;
  assign lo_o = r.lo;

  property p_no_overlap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !(hi_o && lo_o);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both outputs high");

  property p_gap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (active && (lvl_i != r.prev)) |=> (!hi_o && !lo_o);
  endproperty
  a_gap: assert property (p_gap) else $error("no dead gap after change");

  property p_pass;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !active |=> (hi_o == $past(lvl_i)) && (lo_o != hi_o);
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through broken");

  property p_cov_gap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    active && (lvl_i != r.prev);
  endproperty
  c_gap: cover property (p_cov_gap);

endmodule : ccpt_deadtime

// ### verification/ccpt_evt_net.sv
/*
  Event routing network stand-in: sources a count event stream with a
  chosen spacing and counts overflow trigger pulses from the timer.
  Assumes one clock and an asynchronous active-low reset.
*/
module ccpt_evt_net (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] gap_i,
  input  wire logic       ovf_trig_i,
  output logic            evt_o,
  output int unsigned     n_ovf_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_n;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_n  <= 4'h0;
      evt_o   <= 1'b0;
      n_ovf_o <= 0;
    end
    else
    begin
      // gap 0 is prompt, larger gaps are slow
      if (wait_n >= gap_i)
      begin
        wait_n <= 4'h0;
        evt_o  <= ~evt_o;
      end
      else
        wait_n <= wait_n + 4'h1;
      n_ovf_o <= n_ovf_o + (ovf_trig_i ? 1 : 0);
    end
  end
endmodule : ccpt_evt_net

// ### verification/tb.sv
/*
  Self-checking bench: a reference model of the timer, three timer instances
  (first, non-first, wide) and the event network stand-in.
  Assumes the timer package is compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = ccpt_pkg::STD_W;
  localparam int N = ccpt_pkg::CH_N;
  logic sys_clk_i = 0, reset_n_i = 0, run_i = 0, evt_count_i = 0, ovf_clr_i = 0;
  logic dt_enable_i = 0, live = 0, dt_chk = 0, ovf_trig_o, ovf_flag_o, count_evt_i;
  logic [N-1:0][1:0]   chan_mode_i = '0;
  logic [N-1:0]        chan_cap_evt_i = '0;
  logic [N-1:0][W-1:0] chan_thr_i = '0;
  logic [N-1:0][31:0]  wthr;
  logic [7:0]          dt_cycles_i = 8'h00;
  logic [3:0]          gap = 4'h0;
  logic [W-1:0]        count_o;
  logic [31:0]         w_count;
  logic [N-1:0]        match_trig_o, chan_out_o, chan_out_n_o, nd_out, nd_out_n, w_out, w_out_n;
  logic [N-1:0][W-1:0] cap_val_o;
  int unsigned         n_ovf;
  int                  miscompares = 0, n_compared = 0, cyc = 0;
  int                  gap_n [N] = '{default: 0};
  // reference state
  logic [W-1:0] e_cnt;
  logic [31:0]  e_wcnt;
  logic         e_ovf, e_trig, pe;
  logic [N-1:0] pcap, e_lvl, e_out, e_mt;
  logic [N-1:0][W-1:0] e_cap, e_act;

  always_comb
    for (int c = 0; c < N; c++)
      wthr[c] = {16'h0000, chan_thr_i[c]};

  ccpt_timer #(.WIDE(1'b0), .INST_IDX(0)) u_dut (.sys_clk_i, .reset_n_i, .run_i,
    .evt_count_i, .count_evt_i, .ovf_clr_i, .chan_mode_i, .chan_cap_evt_i, .chan_thr_i,
    .dt_enable_i, .dt_cycles_i, .count_o, .ovf_flag_o, .ovf_trig_o, .match_trig_o,
    .cap_val_o, .chan_out_o, .chan_out_n_o);
  ccpt_timer #(.WIDE(1'b0), .INST_IDX(1)) u_nodt (.sys_clk_i, .reset_n_i, .run_i,
    .evt_count_i, .count_evt_i, .ovf_clr_i, .chan_mode_i, .chan_cap_evt_i, .chan_thr_i,
    .dt_enable_i, .dt_cycles_i, .count_o(), .ovf_flag_o(), .ovf_trig_o(), .match_trig_o(),
    .cap_val_o(), .chan_out_o(nd_out), .chan_out_n_o(nd_out_n));
  ccpt_timer #(.WIDE(1'b1), .INST_IDX(0)) u_wide (.sys_clk_i, .reset_n_i, .run_i,
    .evt_count_i, .count_evt_i, .ovf_clr_i, .chan_mode_i, .chan_cap_evt_i,
    .chan_thr_i(wthr), .dt_enable_i, .dt_cycles_i, .count_o(w_count), .ovf_flag_o(),
    .ovf_trig_o(), .match_trig_o(), .cap_val_o(), .chan_out_o(w_out), .chan_out_n_o(w_out_n));
  ccpt_evt_net u_net (.sys_clk_i, .reset_n_i, .gap_i(gap), .ovf_trig_i(ovf_trig_o),
    .evt_o(count_evt_i), .n_ovf_o(n_ovf));

  function automatic logic lvl_of(logic [1:0] m, logic [W-1:0] cnt, thr, act);
    case (m)
      ccpt_pkg::MODE_COMPARE: return cnt >= thr;
      ccpt_pkg::MODE_PWM:     return cnt < act;
      default:                return 1'b0;
    endcase
  endfunction : lvl_of

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin : ref_model
    logic tick;
    logic wrap;
    if (!reset_n_i)
      {e_cnt, e_wcnt, e_ovf, e_trig, pe, pcap, e_lvl, e_out, e_mt, e_cap, e_act} <= '0;
    else
    begin
      tick = run_i && (evt_count_i ? count_evt_i && !pe : 1'b1);
      wrap = tick && (e_cnt == '1);
      pe <= count_evt_i;
      pcap <= chan_cap_evt_i;
      e_cnt <= e_cnt + W'(tick);
      e_wcnt <= e_wcnt + 32'(tick);
      e_trig <= wrap;
      e_ovf <= wrap | (e_ovf & ~ovf_clr_i);
      for (int c = 0; c < N; c++)
      begin
        if (chan_mode_i[c] == ccpt_pkg::MODE_CAPTURE && chan_cap_evt_i[c] && !pcap[c])
          e_cap[c] <= e_cnt;
        if (chan_mode_i[c] != ccpt_pkg::MODE_PWM || wrap)
          e_act[c] <= chan_thr_i[c];
        e_lvl[c] <= lvl_of(chan_mode_i[c], e_cnt, chan_thr_i[c], e_act[c]);
        e_out[c] <= e_lvl[c];
        e_mt[c] <= (chan_mode_i[c] == ccpt_pkg::MODE_COMPARE) ? tick && e_cnt == chan_thr_i[c]
                 : (chan_mode_i[c] == ccpt_pkg::MODE_PWM) && wrap;
      end
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (exp !== got)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  always @(negedge sys_clk_i)
    if (reset_n_i && live)
    begin
      chk("count", 32'(e_cnt), 32'(count_o));
      chk("wide count", e_wcnt, w_count);
      chk("ovf flag", 32'(e_ovf), 32'(ovf_flag_o));
      chk("ovf trig", 32'(e_trig), 32'(ovf_trig_o));
      chk("match trig", 32'(e_mt), 32'(match_trig_o));
      chk("other out", 32'(e_out), 32'(nd_out));
      chk("other out_n", 32'(N'(~e_out)), 32'(nd_out_n));
      chk("overlap", 32'h0000_0000, 32'(chan_out_o & chan_out_n_o));
      if (!dt_enable_i)
      begin
        chk("out", 32'(e_out), 32'(chan_out_o));
        chk("wide out", 32'(e_out), 32'(w_out));
        chk("wide out_n", 32'(N'(~e_out)), 32'(w_out_n));
      end
      chk("wide overlap", 32'h0000_0000, 32'(w_out & w_out_n));
      for (int c = 0; c < N; c++)
        chk("capture", 32'(e_cap[c]), 32'(cap_val_o[c]));
      for (int c = 0; c < N; c++)
        if (!chan_out_o[c] && !chan_out_n_o[c])
          gap_n[c]++;
        else
        begin
          if (dt_chk && gap_n[c] != 0)
            chk("dead gap", 32'(dt_cycles_i) + 32'h0000_0001, 32'(gap_n[c]));
          gap_n[c] = 0;
        end
    end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  initial
    forever #10 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(32'h5765));
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    live <= 1'b1;
    repeat (2000)
    begin
      @(posedge sys_clk_i);
      run_i          <= ($urandom % 8) != 0;
      evt_count_i    <= ($urandom % 4) == 0;
      ovf_clr_i      <= ($urandom % 16) == 0;
      chan_cap_evt_i <= N'($urandom);
      gap            <= 4'($urandom % 4);
      dt_cycles_i    <= 8'($urandom);
      for (int c = 0; c < N; c++)
      begin
        chan_mode_i[c] <= 2'($urandom);
        chan_thr_i[c]  <= e_cnt + W'($urandom % 4);
      end
    end
    $display("test random done");
    // free run to wrap, pwm with dead time, clear held across the wrap
    @(posedge sys_clk_i);
    {run_i, evt_count_i, ovf_clr_i, dt_enable_i} <= 4'b1011;
    dt_cycles_i <= 8'($urandom % 8);
    chan_mode_i <= {N{ccpt_pkg::MODE_PWM}};
    chan_thr_i  <= {16'hFF00, 16'h0000, 16'h8000, 16'hFFF0};
    repeat (40) @(posedge sys_clk_i);
    dt_chk <= 1'b1;
    chan_thr_i <= {16'h0100, 16'h0080, 16'h0000, 16'h0040};
    repeat (70000)
      if (ovf_flag_o !== 1'b1)
        @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    ovf_clr_i <= 1'b0;
    repeat (300) @(posedge sys_clk_i);
    chk("ovf pulses", 32'h0000_0001, 32'(n_ovf));
    $display("test wrap pwm done");
    end_sim();
  end
endmodule : tb
